/* File: verilog/pic_cell.sv */
// Purpose: input, output and tri-state register logic of one i/o cell
// Assumes: pad and core inputs are synchronous to clk_sys
// Notes:   the delay line is modelled in whole clk_sys cycles
//
// Function
// - in single-rate input mode one rising-edge register captures the pad.
// - in double-rate input mode the pad is sampled on both clock edges.
// - rise output carries the rising capture, the second output the falling (the rising in single-rate mode)
// - bypass offers the raw pad as data and as a clock to the core.
// - a fixed delay is offered, and bottom cells add a 5-bit dynamic delay.
// - one system clock runs the input, output and tri-state registers.
// - the local set/reset forces this cell's registers, except the delay line, to the chosen value.
// - the core tri-state control reaches the pad enable via its register.
// - single-rate output passes the first data through a register or latch.
// - double-rate output registers both, re-registers the second on fall.
// - the tri-state control passes one single-rate register.
`timescale 1ns/1ps
`default_nettype none

module pic_cell
    import pic_pkg::*;
(
    input  wire logic          clk_sys,            // system clock
    input  wire logic          rst_b,              // async reset, active low
    input  wire logic          ce,                 // clock enable
    input  wire logic          lsr,                // local set/reset
    input  wire logic          lsr_sets,           // 1: lsr sets, 0: resets
    input  wire logic          pad_in,             // data from pad buffer
    input  wire logic          in_ddr_mode,        // input double-rate
    input  wire pic_dly_mode_t dly_mode,           // input delay choice
    input  wire logic          bottom_edge,        // cell sits on bottom edge
    input  wire logic [4:0]    dynamic_tap_select, // dynamic delay taps
    input  wire logic          out_ddr_mode,       // output double-rate
    input  wire logic          out_latch_mode,     // sdr output as latch
    input  wire logic          core_out_first,     // first output data
    input  wire logic          core_out_second,    // second output data
    input  wire logic          tristate_from_core, // tri-state control in
    output logic               bypass_data_out,    // raw pad data
    output logic               bypass_clock_out,   // raw pad as clock
    output logic               rise_sample_out,    // rising-edge capture
    output logic               fall_sample_out,    // falling/registered input
    output logic               pad_out,            // data to pad buffer
    output logic               tristate_to_pad     // enable to pad buffer
);

    // pick one tap of the delay line, tap 0 being the pad itself
    function automatic logic tap_pick(input logic [LINE_DEPTH-1:0] line,
                                      input logic             din,
                                      input logic [TAP_W-1:0] idx);
        logic res;
        res = din;
        if (idx != TAP_NONE)
        begin
            res = line[idx - 5'h01];
        end
        return res;
    endfunction : tap_pick

    // storage update: lsr first, then hold while clock enable is low
    function automatic logic store(input logic cur, input logic nxt,
                                   input logic en, input logic force_on,
                                   input logic force_val);
        logic res;
        res = cur;
        if (force_on)
        begin
            res = force_val;
        end
        else if (en)
        begin
            res = nxt;
        end
        return res;
    endfunction : store

    logic [LINE_DEPTH-1:0] line_reg;
    logic [LINE_DEPTH-1:0] line_next;
    logic [TAP_W-1:0]      tap_sel;
    logic                  delayed;
    logic                  rise_reg,   rise_next;
    logic                  fall_reg,   fall_next;
    logic                  ofirst_reg, ofirst_next;
    logic                  osec_reg,   osec_next;
    logic                  oneg_reg,   oneg_next;
    logic                  latch_reg,  latch_next;
    logic                  ts_reg,     ts_next;

    // bypass routes the raw pad around delay and registers
    assign bypass_data_out  = pad_in;
    assign bypass_clock_out = pad_in;

    // delay choice: dynamic only exists on the bottom edge
    always_comb
    begin
        tap_sel = TAP_NONE;
        if (dly_mode == PIC_DLY_FIXED)
        begin
            tap_sel = FIXED_TAP;
        end
        else if (dly_mode == PIC_DLY_DYNAMIC && bottom_edge)
        begin
            tap_sel = dynamic_tap_select;
        end
        delayed = tap_pick(line_reg, pad_in, tap_sel);
    end

    // rising-edge group: delay line, input capture, output and tri-state
    always_comb
    begin
        line_next = line_reg;
        if (ce)
        begin
            line_next = {line_reg[LINE_DEPTH-2:0], pad_in};
        end
        rise_next   = store(rise_reg, delayed, ce, lsr, lsr_sets);
        ofirst_next = store(ofirst_reg, core_out_first, ce, lsr,
                            lsr_sets);
        osec_next   = store(osec_reg, core_out_second, ce, lsr,
                            lsr_sets);
        ts_next     = store(ts_reg, tristate_from_core, ce, lsr,
                            lsr_sets);
    end

    // one clock runs every part of the cell
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            line_reg   <= '0;
            rise_reg   <= RESET_VAL;
            ofirst_reg <= RESET_VAL;
            osec_reg   <= RESET_VAL;
            ts_reg     <= RESET_VAL;
        end
        else
        begin
            line_reg   <= line_next;
            rise_reg   <= rise_next;
            ofirst_reg <= ofirst_next;
            osec_reg   <= osec_next;
            ts_reg     <= ts_next;
        end
    end

    // falling-edge group: ddr input, second output stage, latch hold
    always_comb
    begin
        fall_next  = store(fall_reg, delayed, ce, lsr, lsr_sets);
        oneg_next  = store(oneg_reg, osec_reg, ce, lsr, lsr_sets);
        latch_next = store(latch_reg, core_out_first, ce, lsr,
                           lsr_sets);
    end

    // falling edge of the same system clock
    always_ff @(negedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fall_reg  <= RESET_VAL;
            oneg_reg  <= RESET_VAL;
            latch_reg <= RESET_VAL;
        end
        else
        begin
            fall_reg  <= fall_next;
            oneg_reg  <= oneg_next;
            latch_reg <= latch_next;
        end
    end

    // sample outputs and the clock-driven output multiplexer
    always_comb
    begin
        rise_sample_out = rise_reg;
        fall_sample_out = in_ddr_mode ? fall_reg : rise_reg;
        tristate_to_pad = ts_reg;
        if (out_ddr_mode)
        begin
            pad_out = clk_sys ? ofirst_reg : oneg_reg;
        end
        else if (out_latch_mode)
        begin
            // transparent while high; lsr forces it, ce low keeps it shut
            pad_out = latch_reg;
            if (clk_sys && lsr)
            begin
                pad_out = lsr_sets;
            end
            else if (clk_sys && ce)
            begin
                pad_out = core_out_first;
            end
        end
        else
        begin
            pad_out = ofirst_reg;
        end
    end

    // checks on the cell behaviour
    rise_capture_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (ce && !lsr) |=> rise_sample_out == $past(delayed))
        else $error("rising capture missed the pad value");

    fall_capture_a: assert property (
        @(negedge clk_sys) disable iff (!rst_b)
        (ce && !lsr) |=> fall_reg == $past(delayed))
        else $error("falling capture missed the pad value");

    sdr_second_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (!in_ddr_mode && ce && !lsr) ##1 !in_ddr_mode
        |-> fall_sample_out == $past(delayed))
        else $error("second output not the registered input");

    fixed_delay_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ce [*4] ##1 (dly_mode == PIC_DLY_FIXED)
        |-> delayed == $past(pad_in, 4))
        else $error("fixed delay tap wrong");

    lsr_force_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        lsr |=> rise_sample_out == $past(lsr_sets)
            && tristate_to_pad == $past(lsr_sets))
        else $error("local set/reset not applied");

    ts_register_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (ce && !lsr) |=> tristate_to_pad == $past(tristate_from_core))
        else $error("tri-state register did not follow the core");

    sdr_output_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (ce && !lsr && !out_ddr_mode && !out_latch_mode)
        |=> ofirst_reg == $past(core_out_first))
        else $error("single-rate output register wrong");

    ddr_second_a: assert property (
        @(negedge clk_sys) disable iff (!rst_b)
        (ce && !lsr) |=> oneg_reg == $past(osec_reg))
        else $error("second data not re-registered on fall");

    hold_ce_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (!ce && !lsr) |=> $stable(rise_sample_out)
            && $stable(tristate_to_pad) && $stable(line_reg))
        else $error("register moved with clock enable low");

endmodule : pic_cell

`default_nettype wire

/* File: verilog/pic_pkg.sv */
// Purpose: shared constants and types for the pad i/o register cell
// Assumes: one system clock at 250 MHz, asynchronous active-low reset
// Notes:   delay taps are counted in system clock cycles
package pic_pkg;

    // input delay line geometry
    localparam int          TAP_W      = 5;
    localparam int          LINE_DEPTH = 31;
    localparam logic [4:0]  TAP_NONE   = 5'h00;
    localparam logic [4:0]  FIXED_TAP  = 5'h04;

    // reset value of every storage element
    localparam logic        RESET_VAL  = 1'h0;

    // input delay selection
    typedef enum logic [1:0] {
        PIC_DLY_NONE,
        PIC_DLY_FIXED,
        PIC_DLY_DYNAMIC
    } pic_dly_mode_t;

endpackage : pic_pkg

/* File: tb/pic_far_model.sv */
// Purpose: core logic and pad buffer standing beside the i/o cell
// Assumes: the bench hands over the values the core wants to send
// Notes:   second data is junk outside double-rate output
`timescale 1ns/1ps
`default_nettype none

module pic_far_model
(
    input  wire logic clk_sys,            // system clock
    input  wire logic ddr,                // core uses double-rate output
    input  wire logic pad_drive,          // level driven from off chip
    input  wire logic want_first,         // first data wanted by core
    input  wire logic want_second,        // second data wanted by core
    input  wire logic ts,                 // tri-state wanted by core
    input  wire logic pad_out,            // data from the cell
    input  wire logic tristate_to_pad,    // enable from the cell
    output logic      pad_in,             // pad level back to the cell
    output logic      core_out_first,     // first output data
    output logic      core_out_second,    // second output data
    output logic      tristate_from_core  // tri-state control
);
    logic junk = 1'b0;

    // toggling junk so an unused second input never looks valid
    always @(posedge clk_sys) junk <= ~junk;
    assign core_out_first     = want_first;
    assign core_out_second    = ddr ? want_second : junk;
    assign tristate_from_core = ts;
    // pad wire: the cell wins while its enable is high
    assign pad_in = tristate_to_pad ? pad_out : pad_drive;
endmodule : pic_far_model
`default_nettype wire

/* File: tb/pic_cell_tb_top.sv */
// Purpose: self-checking bench for the i/o cell
// Assumes: inputs change at the falling clock edge, except the latch step of t_out, 1 ns after a rising edge
// Notes:   outputs are looked at 1 ns after a clock edge, 1.5 ns in the latch step of t_out
`timescale 1ns/1ps
`default_nettype none

module pic_cell_tb_top;
    import pic_pkg::*;
    logic clk_sys = 0, rst_b = 0, ce = 1, lsr = 0, lsr_sets = 0, bot = 0;
    logic in_ddr = 0, out_ddr = 0, out_latch = 0, pad_drive = 0;
    logic wf = 0, ws = 0, ts = 0;
    logic [4:0] tap = 5'h00;
    pic_dly_mode_t dly = PIC_DLY_NONE;
    wire logic pad_in, cof, cos, tfc, bd, bc, rs, fs, po, tp;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;

    always #2 clk_sys = ~clk_sys;
    pic_cell dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .lsr(lsr),
        .lsr_sets(lsr_sets), .pad_in(pad_in), .in_ddr_mode(in_ddr),
        .dly_mode(dly), .bottom_edge(bot), .dynamic_tap_select(tap),
        .out_ddr_mode(out_ddr), .out_latch_mode(out_latch),
        .core_out_first(cof), .core_out_second(cos),
        .tristate_from_core(tfc), .bypass_data_out(bd),
        .bypass_clock_out(bc), .rise_sample_out(rs), .fall_sample_out(fs),
        .pad_out(po), .tristate_to_pad(tp));
    pic_far_model far_u (.clk_sys(clk_sys), .ddr(out_ddr),
        .pad_drive(pad_drive), .want_first(wf), .want_second(ws),
        .ts(ts), .pad_out(po),
        .tristate_to_pad(tp), .pad_in(pad_in), .core_out_first(cof),
        .core_out_second(cos), .tristate_from_core(tfc));

    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got %b exp %b", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic t_in();
        @(negedge clk_sys);
        pad_drive <= 1'b1;
        #1;
        chk(bd, 1'b1); chk(bc, 1'b1);
        tick(); chk(rs, 1'b1); chk(fs, 1'b1);
        @(negedge clk_sys);
        in_ddr <= 1'b1;
        pad_drive <= 1'b0;
        tick(); chk(rs, 1'b0); chk(fs, 1'b1);
        @(negedge clk_sys);
        in_ddr <= 1'b0;
    endtask : t_in
    task automatic t_delay(input pic_dly_mode_t m, input logic b,
                           input logic [4:0] n, input int exp);
        int k;
        @(negedge clk_sys);
        dly <= m; bot <= b; tap <= n; pad_drive <= 1'b0;
        repeat (40) @(negedge clk_sys);
        pad_drive <= 1'b1;
        k = 0;
        do begin tick(); k++; end while (rs !== 1'b1 && k < 40);
        chk(k == exp, 1'b1);
    endtask : t_delay
    task automatic t_hold();
        @(negedge clk_sys);
        dly <= PIC_DLY_NONE; ce <= 1'b0; pad_drive <= 1'b0; ts <= 1'b1;
        tick(); tick(); chk(rs, 1'b1); chk(tp, 1'b0);
        @(negedge clk_sys);
        lsr <= 1'b1;
        tick(); chk(rs, 1'b0); chk(po, 1'b0);
        @(negedge clk_sys);
        lsr_sets <= 1'b1;
        tick(); chk(rs, 1'b1); chk(tp, 1'b1);
        chk(po, 1'b1);
        @(negedge clk_sys);
        lsr <= 1'b0; ce <= 1'b1; ts <= 1'b0;
        tick(); chk(tp, 1'b0);
    endtask : t_hold
    task automatic t_out();
        @(negedge clk_sys);
        wf <= 1'b1;
        tick(); chk(po, 1'b1);
        @(negedge clk_sys);
        wf <= 1'b0;
        #1 chk(po, 1'b1);
        tick(); chk(po, 1'b0);
        // a latch only shows itself when data moves inside the high phase
        out_latch <= 1'b1; wf <= 1'b1;
        #0.5 chk(po, 1'b1);
        @(negedge clk_sys);
        wf <= 1'b0;
        #1 chk(po, 1'b1);
        @(negedge clk_sys);
        out_ddr <= 1'b1; wf <= 1'b1; ws <= 1'b0;
        tick(); chk(po, 1'b1);
        @(negedge clk_sys);
        wf <= 1'b0; ws <= 1'b1;
        #1 chk(po, 1'b0);
        tick(); chk(po, 1'b0);
        @(negedge clk_sys);
        #1 chk(po, 1'b1);
        @(negedge clk_sys);
        out_ddr <= 1'b0;
    endtask : t_out
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // guard against a hang
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            $display("mismatch t=%0t timeout", $time);
            final_report();
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_sys);
        rst_b <= 1'b1;
        t_in();
        t_delay(PIC_DLY_NONE, 1'b1, 5'h00, 1);
        t_delay(PIC_DLY_FIXED, 1'b0, 5'h00, int'(FIXED_TAP) + 1);
        t_delay(PIC_DLY_DYNAMIC, 1'b1, 5'h07, 8);
        t_delay(PIC_DLY_DYNAMIC, 1'b0, 5'h07, 1);
        t_hold();
        t_out();
        final_report();
    end
endmodule : pic_cell_tb_top
`default_nettype wire
